// *** cpgw_checker.sv ***
// Purpose: port-level assertions for the config port block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every cpgw_top instance
`timescale 1ns/10ps
module cpgw_checker #(
    parameter int PIN_N = 8,
    parameter int TICK_CYC = 10
)(
    input wire logic core_clk,
    input wire logic rstn,
    input cpgw_pkg::cpgw_io_req_t io_req,
    input cpgw_pkg::cpgw_io_rsp_t io_rsp,
    input wire logic [PIN_N-1:0] general_pins_in,
    input wire logic [PIN_N-1:0] general_pins_out,
    input wire logic [PIN_N-1:0] general_pins_oe,
    input wire logic cpu_reset
);
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // index port address, either decode
    wire logic idx_hit = (io_req.addr == cpgw_pkg::CPGW_INDEX_ADDR) ||
        (io_req.addr == cpgw_pkg::CPGW_INDEX_ALT);

    read_answer_a: assert property (io_req.rd |=> io_rsp.rvalid)
        else $error("read strobe got no answer");
    answer_cause_a: assert property (
        io_rsp.rvalid |-> $past(io_req.rd))
        else $error("answer without a read strobe");
    rdata_idle_a: assert property (
        !io_rsp.rvalid |-> io_rsp.rdata == 8'h00)
        else $error("read byte not zero while idle");
    index_wo_a: assert property (io_req.rd && idx_hit |=>
        io_rsp.rdata == 8'h00)
        else $error("index port returned data");
    reset_pins_a: assert property ($rose(rstn) |->
        general_pins_oe == '0 &&
        general_pins_out == '0 && !cpu_reset)
        else $error("outputs wrong after reset");
    pins_quiet_a: assert property (($changed(general_pins_oe) ||
        $changed(general_pins_out)) |-> ($past(io_req.wr, 1) ||
        $past(io_req.wr, 2) || $past(io_req.wr, 3)))
        else $error("pins changed without a host write");
    wd_drop_cause_a: assert property ($fell(cpu_reset) |->
        ($past(io_req.wr, 1) || $past(io_req.wr, 2)))
        else $error("processor reset dropped without a write");
    wd_hold_a: assert property (cpu_reset && !io_req.wr &&
        !$past(io_req.wr) |=> cpu_reset)
        else $error("processor reset not held");

    // main scenarios reached
    cover property (io_rsp.rvalid && io_rsp.rdata != 8'h00);
    cover property ($rose(cpu_reset));
    cover property ($changed(general_pins_oe));
endmodule : cpgw_checker

bind cpgw_top cpgw_checker #(.PIN_N(PIN_N), .TICK_CYC(TICK_CYC)) chk_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .io_req(io_req),
    .io_rsp(io_rsp),
    .general_pins_in(general_pins_in),
    .general_pins_out(general_pins_out),
    .general_pins_oe(general_pins_oe),
    .cpu_reset(cpu_reset)
);

// *** cpgw_host.sv ***
// Purpose: host processor model issuing port writes and reads
// Assumes: one-cycle strobes launched at the rising edge
// Notes: released bus shows the inverse of the last address and data
`timescale 1ns/10ps
module cpgw_host (
    input wire logic core_clk,
    output cpgw_pkg::cpgw_io_req_t io_req,
    input cpgw_pkg::cpgw_io_rsp_t io_rsp
);
    // ****************************************************************
    // port cycles
    // ****************************************************************
    initial io_req = '0;

    // one write strobe, then bus released
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        io_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    // one read strobe; answer taken one edge later
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        d = 8'hxx;
        @(posedge core_clk);
        io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        io_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        @(posedge core_clk);
        if (io_rsp.rvalid === 1'b1)
            d = io_rsp.rdata;
    endtask : rd

    // key pair opens, exit byte closes
    task automatic enter(input logic [15:0] ia);
        wr(ia, cpgw_pkg::CPGW_KEY_ENTER);
        wr(ia, cpgw_pkg::CPGW_KEY_ENTER);
    endtask : enter

    task automatic leave(input logic [15:0] ia);
        wr(ia, cpgw_pkg::CPGW_KEY_EXIT);
    endtask : leave

    // choose a bank, then write one indexed register
    task automatic reg_wr(input logic [15:0] ia, input logic [7:0] u,
        input logic [7:0] i, input logic [7:0] v);
        wr(ia, cpgw_pkg::CPGW_IDX_UNIT);
        wr(ia + 16'h0001, u);
        wr(ia, i);
        wr(ia + 16'h0001, v);
    endtask : reg_wr

    // choose a bank, then read one indexed register
    task automatic reg_rd(input logic [15:0] ia, input logic [7:0] u,
        input logic [7:0] i, output logic [7:0] v);
        wr(ia, cpgw_pkg::CPGW_IDX_UNIT);
        wr(ia + 16'h0001, u);
        wr(ia, i);
        rd(ia + 16'h0001, v);
    endtask : reg_rd
endmodule : cpgw_host

// *** cpgw_pkg.sv ***
// Purpose: shared constants and carriers for the config port block
// Assumes: 8-bit host i/o port accesses, one system clock
// Notes: addresses, indexes and reset values live here only
package cpgw_pkg;

    // ****************************************************************
    // host port addresses
    // ****************************************************************
    localparam logic [15:0] CPGW_INDEX_ADDR = 16'h002E; // index port
    localparam logic [15:0] CPGW_INDEX_ALT = 16'h004E;  // alternate index
    localparam logic [15:0] CPGW_DATA_ADDR = 16'h002F;  // data port
    localparam logic [15:0] CPGW_DATA_ALT = 16'h004F;   // alternate data

    // ****************************************************************
    // key bytes and indexes
    // ****************************************************************
    localparam logic [7:0] CPGW_KEY_ENTER = 8'h87;   // written twice
    localparam logic [7:0] CPGW_KEY_EXIT = 8'hAA;    // leaves config
    localparam logic [7:0] CPGW_IDX_UNIT = 8'h07;    // unit number reg
    localparam logic [7:0] CPGW_IDX_DIR = 8'hF0;     // pin direction
    localparam logic [7:0] CPGW_IDX_DATA = 8'hF1;    // pin data
    localparam logic [7:0] CPGW_IDX_INV = 8'hF2;     // pin inversion
    localparam logic [7:0] CPGW_IDX_WDACT = 8'h30;   // watchdog activate
    localparam logic [7:0] CPGW_IDX_WDTIME = 8'hF6;  // watchdog seconds
    localparam logic [7:0] CPGW_UNIT_GPIO = 8'h07;   // gpio bank
    localparam logic [7:0] CPGW_UNIT_WDOG = 8'h08;   // watchdog bank

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] CPGW_DIR_RST = 8'hFF;     // all inputs
    localparam logic [7:0] CPGW_DATA_RST = 8'h00;    // data cleared
    localparam logic [7:0] CPGW_INV_RST = 8'h00;     // no inversion
    localparam logic [7:0] CPGW_ZERO8 = 8'h00;       // general zero
    localparam logic [7:0] CPGW_WDACT_ON = 8'h01;    // activate value

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CPGW_CLK_HZ = 40_000_000;         // core clock rate
    localparam int CPGW_SECOND_S = 1;                // one tick, seconds
    localparam int CPGW_SECOND_CYC = CPGW_CLK_HZ * CPGW_SECOND_S;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;  // port address
        logic [7:0] wdata;  // write byte
        logic wr;           // write strobe, one cycle
        logic rd;           // read strobe, one cycle
    } cpgw_io_req_t;

    typedef struct packed {
        logic [7:0] rdata;  // read byte
        logic rvalid;       // read answer, one cycle
    } cpgw_io_rsp_t;

endpackage : cpgw_pkg

// *** cpgw_top.sv ***
// Purpose: config port decode, gpio bank and watchdog bank
// Assumes: host gives one-cycle read and write strobes per access
// Notes: pins are sampled through two flops before use
`timescale 1ns/10ps

// Contract
// RL1: direction bit one input, zero output
// RL2: direction resets to all ones
// RL3: output pin data bit writable, readable
// RL4: input pin data bit read-only
// RL5: pin data resets to zero
// RL6: inversion bit inverts both directions
// RL7: inversion resets to zero
// RL8: index port write-only at 2E or 4E
// RL9: data port at 2F or 4F, indexed
// RL10: double 87 write enters config mode
// RL11: AA write to index exits mode
// RL12: index 07 selects logical unit number
// RL13: gpio bank unit 7, F0 F1 F2
// RL14: unit 8 index 30 one activates watchdog
// RL15: unit 8 index 30 zero deactivates
// RL16: unit 8 index F6 loads seconds
// RL17: expiry resets the processor
// RL18: counts down per second, reload, expire
// RL19: data port inert outside config mode
module cpgw_top #(
    parameter int PIN_N = 8,
    parameter int TICK_CYC = cpgw_pkg::CPGW_SECOND_CYC
)(
    input wire logic core_clk,
    input wire logic rstn,
    input cpgw_pkg::cpgw_io_req_t io_req,
    output cpgw_pkg::cpgw_io_rsp_t io_rsp,
    input wire logic [PIN_N-1:0] general_pins_in,
    output logic [PIN_N-1:0] general_pins_out,
    output logic [PIN_N-1:0] general_pins_oe,
    output logic cpu_reset
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic hit_index;          // access to index port
    logic hit_data;           // access to data port
    logic idx_wr;             // index port write
    logic dat_wr;             // data port write, config open
    logic dat_rd;             // data port read

    assign hit_index = (io_req.addr == cpgw_pkg::CPGW_INDEX_ADDR)
                    || (io_req.addr == cpgw_pkg::CPGW_INDEX_ALT); // see RL8
    assign hit_data = (io_req.addr == cpgw_pkg::CPGW_DATA_ADDR)
                   || (io_req.addr == cpgw_pkg::CPGW_DATA_ALT); // see RL9
    assign idx_wr = io_req.wr && hit_index;
    assign dat_rd = io_req.rd && hit_data;

    // ****************************************************************
    // key sequence
    // ****************************************************************
    typedef enum logic [1:0] {
        CPGW_LOCKED,
        CPGW_HALF_KEY,
        CPGW_OPEN
    } cpgw_mode_t;

    cpgw_mode_t mode_ff;      // config mode state
    cpgw_mode_t nxt_mode;
    logic cfg_open;           // config access allowed
    logic key_hit;            // index write of enter key
    logic exit_hit;           // index write of exit key

    assign key_hit = idx_wr && (io_req.wdata == cpgw_pkg::CPGW_KEY_ENTER);
    assign exit_hit = idx_wr && (io_req.wdata == cpgw_pkg::CPGW_KEY_EXIT);
    assign cfg_open = (mode_ff == CPGW_OPEN);
    assign dat_wr = io_req.wr && hit_data && cfg_open; // see RL19

    // next mode from index port writes
    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            CPGW_LOCKED:
            begin
                if (key_hit)
                    nxt_mode = CPGW_HALF_KEY;
            end
            CPGW_HALF_KEY:
            begin
                // any other index write breaks the pair
                if (key_hit)
                    nxt_mode = CPGW_OPEN; // see RL10
                else if (idx_wr)
                    nxt_mode = CPGW_LOCKED;
            end
            CPGW_OPEN:
            begin
                if (exit_hit)
                    nxt_mode = CPGW_LOCKED; // see RL11
            end
            // the spare code falls back to locked
            default: nxt_mode = CPGW_LOCKED;
        endcase
    end

    // ****************************************************************
    // index and unit number
    // ****************************************************************
    logic [7:0] index_ff;     // selected register index
    logic [7:0] nxt_index;
    logic [7:0] unit_ff;      // logical unit number
    logic [7:0] nxt_unit;
    logic sel_unit;           // index points at unit number
    logic in_gpio;            // gpio bank selected
    logic in_wdog;            // watchdog bank selected

    // index only follows writes while config is open
    assign nxt_index = (idx_wr && cfg_open) ? io_req.wdata : index_ff;
    assign sel_unit = (index_ff == cpgw_pkg::CPGW_IDX_UNIT);
    assign nxt_unit = (dat_wr && sel_unit) ? io_req.wdata
                                           : unit_ff; // see RL12
    assign in_gpio = (unit_ff == cpgw_pkg::CPGW_UNIT_GPIO); // see RL13
    assign in_wdog = (unit_ff == cpgw_pkg::CPGW_UNIT_WDOG); // see RL14

    // ****************************************************************
    // gpio bank
    // ****************************************************************
    logic [PIN_N-1:0] dir_ff;     // one means input
    logic [PIN_N-1:0] nxt_dir;
    logic [PIN_N-1:0] pdata_ff;   // stored output data
    logic [PIN_N-1:0] nxt_pdata;
    logic [PIN_N-1:0] inv_ff;     // inversion mask
    logic [PIN_N-1:0] nxt_inv;
    logic [PIN_N-1:0] pin_s1_ff;  // first sync stage
    logic [PIN_N-1:0] pin_s2_ff;  // second sync stage
    logic [PIN_N-1:0] pdata_view; // data register as read
    logic [PIN_N-1:0] out_ff;     // pin drive level
    logic [PIN_N-1:0] oe_ff;      // pin drive enable
    logic wr_dir;
    logic wr_pdata;
    logic wr_inv;

    assign wr_dir = dat_wr && in_gpio
                 && (index_ff == cpgw_pkg::CPGW_IDX_DIR);
    assign wr_pdata = dat_wr && in_gpio
                   && (index_ff == cpgw_pkg::CPGW_IDX_DATA);
    assign wr_inv = dat_wr && in_gpio
                 && (index_ff == cpgw_pkg::CPGW_IDX_INV);
    assign nxt_dir = wr_dir ? io_req.wdata[PIN_N-1:0] : dir_ff;
    assign nxt_inv = wr_inv ? io_req.wdata[PIN_N-1:0] : inv_ff;
    // only output bits take the write; input bits keep their value
    assign nxt_pdata = wr_pdata
        ? ((io_req.wdata[PIN_N-1:0] & ~dir_ff) | (pdata_ff & dir_ff))
        : pdata_ff; // see RL3 RL4
    // inputs read the pin, outputs read back the stored bit
    assign pdata_view = (dir_ff & (pin_s2_ff ^ inv_ff))
                      | (~dir_ff & pdata_ff); // see RL6

    // gpio registers and pin synchroniser
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dir_ff <= PIN_N'(cpgw_pkg::CPGW_DIR_RST); // see RL2
            pdata_ff <= PIN_N'(cpgw_pkg::CPGW_DATA_RST); // see RL5
            inv_ff <= PIN_N'(cpgw_pkg::CPGW_INV_RST); // see RL7
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end
        else
        begin
            dir_ff <= nxt_dir;
            pdata_ff <= nxt_pdata;
            inv_ff <= nxt_inv;
            pin_s1_ff <= general_pins_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // pin drivers registered from the bank state
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            out_ff <= '0;
            oe_ff <= '0;
        end
        else
        begin
            out_ff <= pdata_ff ^ inv_ff; // see RL6
            oe_ff <= ~dir_ff; // see RL1
        end
    end

    assign general_pins_out = out_ff;
    assign general_pins_oe = oe_ff;

    // ****************************************************************
    // watchdog bank
    // ****************************************************************
    logic wd_act_ff;          // watchdog active
    logic nxt_wd_act;
    logic [7:0] wd_time_ff;   // last written timeout
    logic [7:0] nxt_wd_time;
    logic wr_wdact;
    logic wd_load;            // timeout write pulse
    logic wd_expired;
    logic [7:0] wd_remain;

    assign wr_wdact = dat_wr && in_wdog
                   && (index_ff == cpgw_pkg::CPGW_IDX_WDACT);
    assign wd_load = dat_wr && in_wdog
                  && (index_ff == cpgw_pkg::CPGW_IDX_WDTIME); // see RL16
    // only the byte 01 activates; any other byte deactivates
    assign nxt_wd_act = wr_wdact
        ? (io_req.wdata == cpgw_pkg::CPGW_WDACT_ON)
        : wd_act_ff; // see RL14 RL15
    assign nxt_wd_time = wd_load ? io_req.wdata : wd_time_ff;

    // watchdog control registers
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wd_act_ff <= 1'b0;
            wd_time_ff <= cpgw_pkg::CPGW_ZERO8;
        end
        else
        begin
            wd_act_ff <= nxt_wd_act;
            wd_time_ff <= nxt_wd_time;
        end
    end

    cpgw_wdog #(
        .TICK_CYC(TICK_CYC)
    ) u_wdog (
        .core_clk(core_clk),
        .rstn(rstn),
        .active(wd_act_ff),
        .load(wd_load),
        .load_val(io_req.wdata),
        .expired(wd_expired),
        .remain(wd_remain)
    );

    assign cpu_reset = wd_expired; // see RL17

    // ****************************************************************
    // read mux
    // ****************************************************************
    logic [7:0] rd_mux;       // selected read byte
    logic [7:0] gpio_rd;      // gpio bank read
    logic [7:0] wdog_rd;      // watchdog bank read
    logic [7:0] rdata_ff;
    logic rvalid_ff;

    assign gpio_rd = (index_ff == cpgw_pkg::CPGW_IDX_DIR)
                   ? 8'(dir_ff)
                   : (index_ff == cpgw_pkg::CPGW_IDX_DATA)
                   ? 8'(pdata_view)
                   : (index_ff == cpgw_pkg::CPGW_IDX_INV)
                   ? 8'(inv_ff) : cpgw_pkg::CPGW_ZERO8;
    // timeout index reads the seconds still left
    assign wdog_rd = (index_ff == cpgw_pkg::CPGW_IDX_WDACT)
                   ? {7'h00, wd_act_ff}
                   : (index_ff == cpgw_pkg::CPGW_IDX_WDTIME)
                   ? wd_remain : cpgw_pkg::CPGW_ZERO8;
    // closed mode and index port reads return zero
    assign rd_mux = !cfg_open ? cpgw_pkg::CPGW_ZERO8
                  : sel_unit ? unit_ff
                  : in_gpio ? gpio_rd
                  : in_wdog ? wdog_rd
                  : cpgw_pkg::CPGW_ZERO8; // see RL19

    // mode, index and read answer registers
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            mode_ff <= CPGW_LOCKED;
            index_ff <= cpgw_pkg::CPGW_ZERO8;
            unit_ff <= cpgw_pkg::CPGW_ZERO8;
            rdata_ff <= cpgw_pkg::CPGW_ZERO8;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            index_ff <= nxt_index;
            unit_ff <= nxt_unit;
            rdata_ff <= dat_rd ? rd_mux : cpgw_pkg::CPGW_ZERO8;
            rvalid_ff <= io_req.rd;
        end
    end

    // one driver for the whole answer carrier
    assign io_rsp = '{rdata: rdata_ff, rvalid: rvalid_ff};

endmodule : cpgw_top

// *** cpgw_top_tb.sv ***
// Purpose: self-checking bench for the config port block
// Assumes: tick shortened to ten cycles per second
// Notes: reset first, then table rows, lock, watchdog and rerun cases
`timescale 1ns/10ps
module cpgw_top_tb;
    // ****************************************************************
    // bench signals
    // ****************************************************************
    localparam int TICK = 10; // cycles per watchdog second
    localparam logic [15:0] IA = cpgw_pkg::CPGW_INDEX_ADDR;
    localparam logic [15:0] IB = cpgw_pkg::CPGW_INDEX_ALT;
    typedef struct packed {
        logic [7:0] unit, idx, wv, rv, oe, out;
    } cpgw_row_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] pins_in = 8'h09; // low nibble inputs read this
    cpgw_pkg::cpgw_io_req_t io_req;
    cpgw_pkg::cpgw_io_rsp_t io_rsp;
    logic [7:0] pins_out;
    logic [7:0] pins_oe;
    logic cpu_reset;
    logic [7:0] got;
    logic [7:0] held;
    int n;
    int num_errors = 0;
    int num_checks = 0;
    // unit, index, write, read back, oe, out
    cpgw_row_t rows [6] = '{
        '{8'h07, 8'hF0, 8'h0F, 8'h0F, 8'hF0, 8'h00},
        '{8'h07, 8'hF2, 8'h3C, 8'h3C, 8'hF0, 8'h3C},
        '{8'h07, 8'hF1, 8'hA5, 8'hA5, 8'hF0, 8'h9C},
        '{8'h08, 8'hF6, 8'h20, 8'h20, 8'hF0, 8'h9C},
        '{8'h07, 8'hE0, 8'h55, 8'h00, 8'hF0, 8'h9C},
        '{8'h09, 8'hF0, 8'h00, 8'h00, 8'hF0, 8'h9C}};

    always #12.5 core_clk = ~core_clk;

    cpgw_top #(.PIN_N(8), .TICK_CYC(TICK)) dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .io_req(io_req),
        .io_rsp(io_rsp),
        .general_pins_in(pins_in),
        .general_pins_out(pins_out),
        .general_pins_oe(pins_oe),
        .cpu_reset(cpu_reset)
    );
    cpgw_host host (.core_clk(core_clk), .io_req(io_req), .io_rsp(io_rsp));

    // ****************************************************************
    // compare and close
    // ****************************************************************
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // hang guard, far beyond the expected run
    initial
    begin
        #(25 * 8000);
        num_errors++;
        report_and_stop();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk("oe reset", 8'h00, pins_oe);
        chk("out reset", 8'h00, pins_out);
        host.enter(IA);
        host.reg_rd(IA, 8'h07, 8'hF0, got);
        chk("dir reset", 8'hFF, got);
        host.reg_rd(IA, 8'h07, 8'hF1, got);
        chk("data reset", 8'h09, got);
        host.reg_rd(IA, 8'h07, 8'hF2, got);
        chk("inv reset", 8'h00, got);
        $display("test reset done");
        // table rows through the data window
        foreach (rows[i])
        begin
            host.reg_wr(IA, rows[i].unit, rows[i].idx, rows[i].wv);
            host.reg_rd(IA, rows[i].unit, rows[i].idx, got);
            chk("row read", rows[i].rv, got);
            chk("row oe", rows[i].oe, pins_oe);
            chk("row out", rows[i].out, pins_out);
        end
        $display("test rows done");
        // all outputs: input bits kept their stored zeros
        host.reg_wr(IA, 8'h07, 8'hF0, 8'h00);
        host.reg_rd(IA, 8'h07, 8'hF1, got);
        chk("kept bits", 8'hA0, got);
        chk("oe all", 8'hFF, pins_oe);
        host.rd(IA, got);
        chk("index read", 8'h00, got);
        // closed: data window inert, broken key pair refused
        host.leave(IA);
        // a closed index write must not point the window anywhere
        host.wr(IA, cpgw_pkg::CPGW_IDX_UNIT);
        host.wr(IA + 16'h0001, 8'hFF);
        host.rd(IA + 16'h0001, got);
        chk("closed read", 8'h00, got);
        host.wr(IB, cpgw_pkg::CPGW_KEY_ENTER);
        host.wr(IB, 8'h07);
        host.wr(IB, cpgw_pkg::CPGW_KEY_ENTER);
        // if the split pair had opened, this would select the unit reg
        host.wr(IB, cpgw_pkg::CPGW_IDX_UNIT);
        host.rd(IB + 16'h0001, got);
        chk("broken key", 8'h00, got);
        host.enter(IB);
        host.reg_rd(IB, 8'h07, 8'hF1, got);
        chk("alt ports", 8'hA0, got);
        chk("out kept", 8'h9C, pins_out);
        $display("test lock done");
        // watchdog: load, activate, expire, reload, stop
        host.reg_wr(IA, 8'h08, 8'hF6, 8'h03);
        host.reg_wr(IA, 8'h08, 8'h30, 8'h01);
        chk("wd early", 8'h00, {7'h0, cpu_reset});
        n = 0;
        while (cpu_reset !== 1'b1 && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("expiry", 8'h01,
            {7'h0, n >= 2*TICK-2 && n <= 3*TICK+4});
        host.reg_wr(IA, 8'h08, 8'hF6, 8'h05);
        @(posedge core_clk);
        chk("reload", 8'h00, {7'h0, cpu_reset});
        host.reg_rd(IA, 8'h08, 8'hF6, got);
        chk("count", 8'h01, {7'h0, got inside {8'h04, 8'h05}});
        host.reg_wr(IA, 8'h08, 8'h30, 8'h00);
        host.reg_rd(IA, 8'h08, 8'hF6, held);
        repeat (8*TICK) @(posedge core_clk);
        host.reg_rd(IA, 8'h08, 8'hF6, got);
        chk("wd stopped", held, got);
        chk("no reset", 8'h00, {7'h0, cpu_reset});
        $display("test watchdog done");
        // second reset in mid-run
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk("oe rerun", 8'h00, pins_oe);
        chk("out rerun", 8'h00, pins_out);
        $display("test rerun done");
        report_and_stop();
    end
endmodule : cpgw_top_tb

// *** cpgw_wdog.sv ***
// Purpose: watchdog counting whole seconds down to a processor reset
// Assumes: load pulses come from the config register logic
// Notes: tick divider length is a parameter so tests can shorten it
`timescale 1ns/10ps
module cpgw_wdog #(
    parameter int TICK_CYC = cpgw_pkg::CPGW_SECOND_CYC
)(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic active,
    input wire logic load,
    input wire logic [7:0] load_val,
    output logic expired,
    output logic [7:0] remain
);

    // ****************************************************************
    // second divider and counter
    // ****************************************************************
    logic [31:0] div_ff;      // cycles within current second
    logic [31:0] nxt_div;
    logic [7:0] cnt_ff;       // seconds left
    logic [7:0] nxt_cnt;
    logic expired_ff;         // reset request, held
    logic nxt_expired;
    logic running;            // counting allowed
    logic tick;               // one-second pulse

    assign running = active && (cnt_ff != cpgw_pkg::CPGW_ZERO8);
    assign tick = running && (div_ff == 32'(TICK_CYC - 1));
    assign nxt_div = (!running || load || tick) ? 32'h0000_0000
                                                : div_ff + 32'h0000_0001;
    // reload on write, else step once per second
    assign nxt_cnt = load ? load_val
                   : (tick ? cnt_ff - 8'h01 : cnt_ff); // see RL18
    // expiry when the last second runs out while active
    assign nxt_expired = load ? 1'b0
                       : (!active ? 1'b0
                       : (expired_ff || (tick && cnt_ff == 8'h01)));

    // state update
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            div_ff <= 32'h0000_0000;
            cnt_ff <= cpgw_pkg::CPGW_ZERO8;
            expired_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            cnt_ff <= nxt_cnt;
            expired_ff <= nxt_expired; // see RL17
        end
    end

    assign expired = expired_ff;
    assign remain = cnt_ff;

endmodule : cpgw_wdog
